// File: inc/apfm_cfg.svh
`ifndef APFM_CFG_SVH
`define APFM_CFG_SVH
`define APFM_NCH 4
`define APFM_CLK_HZ 20000000
`define APFM_WIN_MS 200
`define APFM_WIN_CYC ((`APFM_CLK_HZ / 1000) * `APFM_WIN_MS)
`define APFM_LCF_MS 800
`define APFM_LCF_CYC ((`APFM_CLK_HZ / 1000) * `APFM_LCF_MS)
`define APFM_LIM4_MS 10
`define APFM_LIM4_CYC ((`APFM_CLK_HZ / 1000) * `APFM_LIM4_MS)
`define APFM_ZC_WAIT_US 20
`define APFM_ZC_WAIT_CYC ((`APFM_CLK_HZ / 1000000) * `APFM_ZC_WAIT_US)
`define APFM_INIT_CYC 16
`define APFM_GAIN_MAX_STEPS 5'h18
`define APFM_PIN_FAULT 4'h0
`define APFM_PIN_WARN 4'h1
`define APFM_PIN_CLIP1 4'h2
`define APFM_PIN_CLIP2 4'h3
`define APFM_GP_HIZ 4'h0
`define APFM_GP_WARN 4'h1
`define APFM_GP_FAULT 4'h2
`define APFM_GP_CLIP1 4'h3
`define APFM_GP_CLIP2 4'h4
`define APFM_FCFG1_RST 8'h0f
`define APFM_FCFG2_RST 8'h00
`define APFM_WCFG_RST 8'h01
`define APFM_F_OVERCURRENT_SHUTDOWN_EVENT 0
`define APFM_F_DC 1
`define APFM_F_LCF 2
`define APFM_F_THERMAL_SHUTDOWN_EVENT 3
`define APFM_F_PWR 4
`define APFM_F_PSD 5
`define APFM_F_WARN 6
`define APFM_W_OTW 0
`define APFM_W_THERMAL_GAIN_REDUCTION 1
`define APFM_W_LCW 2
`define APFM_W_PWR 3
`define APFM_W_THERMAL_SHUTDOWN_EVENT 4
`define APFM_W_CLIP 5
`endif

// File: inc/apfm_pkg.sv
package apfm_pkg;
  typedef enum logic [1:0] {APFM_OC_L1, APFM_OC_L2, APFM_OC_L3, APFM_OC_L4} apfm_oc_level_t;
  typedef enum logic [1:0] {APFM_CLIP_1P, APFM_CLIP_2P, APFM_CLIP_5P, APFM_CLIP_10P} apfm_clip_thr_t;
  typedef enum logic [1:0] {APFM_GRP_12, APFM_GRP_34, APFM_GRP_ALL, APFM_GRP_NONE} apfm_clip_map_t;
  typedef enum logic [1:0] {APFM_INIT, APFM_RUN} apfm_state_t;
endpackage

// File: rtl/apfm_monitor.sv
// Behaviour
// - overcurrent trips event, limits current, channel shutdown
// - four overcurrent levels, each sets current limit
// - dc offset fault shuts channel down
// - limiter monitoring separate per channel
// - limiter half of 200 ms: load warning
// - load warning 800 ms unbroken: load fault
// - level four: limiter over 10 ms faults
// - clip warning when enabled, threshold selectable
// - two clip groups routable to pins
// - global overtemperature shuts all channels
// - channel overtemperature shuts that channel only
// - auto recovery restores after cooling
// - global warning level selectable, channel fixed
// - thermal warning drives warning signal by default
// - foldback attenuates 0.5 dB steps to 12 dB
// - release in same steps, rates programmable
// - steps gated by zero crossing, wait time
// - foldback warning while gain below 0 dB
// - supply faults shut down, report power event
// - error pin low until ready after reset
// - fault pin sources configurable, defaults set
// - pin select code chooses fault or warning
// - pin select leaves protection untouched
// - codes 0010/0011 output clip groups high
// - warning signal defaults to latched thermal warning
`timescale 1ns/1ps
`include "apfm_cfg.svh"
module apfm_monitor
  import apfm_pkg::*;
#(
  parameter int unsigned WIN_CYC = `APFM_WIN_CYC,
  parameter int unsigned LCF_CYC = `APFM_LCF_CYC,
  parameter int unsigned LIM4_CYC = `APFM_LIM4_CYC,
  parameter int unsigned INIT_CYC = `APFM_INIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] oc_detect,
  input wire logic [3:0] dc_detect,
  input wire logic [3:0] limit_active,
  input wire logic [3:0] clip_detect,
  input wire logic [3:0] ch_ot_shutdown,
  input wire logic [3:0] ch_ot_warning,
  input wire logic global_ot_shutdown,
  input wire logic global_ot_warning,
  input wire logic supply_fault,
  input wire logic zero_cross,
  input wire logic [1:0] oc_level,
  input wire logic [1:0] global_warn_level,
  input wire logic clip_enable,
  input wire logic [1:0] clip_threshold,
  input wire logic [1:0] clip_map_grp1,
  input wire logic [1:0] clip_map_grp2,
  input wire logic auto_recover,
  input wire logic foldback_enable,
  input wire logic zc_enable,
  input wire logic [7:0] zc_wait_cyc,
  input wire logic [15:0] attack_cyc,
  input wire logic [15:0] release_cyc,
  input wire logic [7:0] fault_cfg1,
  input wire logic [7:0] fault_cfg2,
  input wire logic [7:0] warn_cfg,
  input wire logic [3:0] fault_pin_sel,
  input wire logic [3:0] gpio_a_sel,
  input wire logic [3:0] gpio_b_sel,
  input wire logic [3:0] clear_overcurrent_shutdown_event,
  input wire logic [3:0] clear_dc,
  input wire logic [3:0] clear_lcf,
  input wire logic [3:0] clear_lcw,
  input wire logic [3:0] clear_clip,
  input wire logic [3:0] clear_thermal_shutdown_event,
  input wire logic clear_power,
  input wire logic clear_otw,
  output logic [3:0] dynamic_current_limit_en,
  output logic [1:0] shutdown_current_threshold,
  output logic [1:0] dynamic_current_limit,
  output logic [1:0] dc_offset_threshold,
  output logic [1:0] clip_level,
  output logic [1:0] global_warn_threshold,
  output logic [3:0] channel_hiz,
  output logic [3:0] overcurrent_shutdown_event,
  output logic [3:0] dc_fault_event,
  output logic [3:0] load_warning_event,
  output logic [3:0] load_fault_event,
  output logic [3:0] clip_warning_event,
  output logic [3:0] thermal_shutdown_event,
  output logic [3:0] thermal_warning_event,
  output logic global_thermal_warning_event,
  output logic power_fault_event,
  output logic thermal_gain_reduction,
  output logic [4:0] atten_steps,
  output logic fault_signal,
  output logic warning_signal,
  output logic [1:0] clip_group,
  output logic ready,
  output logic fault_pin_o,
  output logic fault_pin_oe,
  output logic general_pin_a_o,
  output logic general_pin_a_oe,
  output logic general_pin_b_o,
  output logic general_pin_b_oe
);

  function automatic logic [3:0] sync3(input logic [3:0] s2, input logic [3:0] s3, input logic [3:0] prev);
    sync3 = (s2 == s3) ? s3 : prev;
  endfunction

  function automatic logic grp_sel(input logic [1:0] m, input logic [3:0] c);
    case (m)
      2'h0: grp_sel = c[0] | c[1];
      2'h1: grp_sel = c[2] | c[3];
      2'h2: grp_sel = |c;
      default: grp_sel = 1'b0;
    endcase
  endfunction

  // three-stage input capture, change accepted when stages two and three agree
  logic [3:0] oc_s1, oc_s2, oc_s3, oc_q;
  logic [3:0] dc_s1, dc_s2, dc_s3, dc_q;
  logic [3:0] lim_s1, lim_s2, lim_s3, lim_q;
  logic [3:0] clp_s1, clp_s2, clp_s3, clp_q;
  logic [3:0] cts_s1, cts_s2, cts_s3, cts_q;
  logic [3:0] ctw_s1, ctw_s2, ctw_s3, ctw_q;
  logic [3:0] glb_s1, glb_s2, glb_s3, glb_q;
  logic [3:0] glb_in;
  assign glb_in = {zero_cross, supply_fault, global_ot_warning, global_ot_shutdown};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {oc_s1, oc_s2, oc_s3, oc_q} <= 16'h0000;
      {dc_s1, dc_s2, dc_s3, dc_q} <= 16'h0000;
      {lim_s1, lim_s2, lim_s3, lim_q} <= 16'h0000;
      {clp_s1, clp_s2, clp_s3, clp_q} <= 16'h0000;
      {cts_s1, cts_s2, cts_s3, cts_q} <= 16'h0000;
      {ctw_s1, ctw_s2, ctw_s3, ctw_q} <= 16'h0000;
      {glb_s1, glb_s2, glb_s3, glb_q} <= 16'h0000;
    end else begin
      oc_s1 <= oc_detect; oc_s2 <= oc_s1; oc_s3 <= oc_s2; oc_q <= sync3(oc_s2, oc_s3, oc_q);
      dc_s1 <= dc_detect; dc_s2 <= dc_s1; dc_s3 <= dc_s2; dc_q <= sync3(dc_s2, dc_s3, dc_q);
      lim_s1 <= limit_active; lim_s2 <= lim_s1; lim_s3 <= lim_s2; lim_q <= sync3(lim_s2, lim_s3, lim_q);
      clp_s1 <= clip_detect; clp_s2 <= clp_s1; clp_s3 <= clp_s2; clp_q <= sync3(clp_s2, clp_s3, clp_q);
      cts_s1 <= ch_ot_shutdown; cts_s2 <= cts_s1; cts_s3 <= cts_s2; cts_q <= sync3(cts_s2, cts_s3, cts_q);
      ctw_s1 <= ch_ot_warning; ctw_s2 <= ctw_s1; ctw_s3 <= ctw_s2; ctw_q <= sync3(ctw_s2, ctw_s3, ctw_q);
      glb_s1 <= glb_in; glb_s2 <= glb_s1; glb_s3 <= glb_s2; glb_q <= sync3(glb_s2, glb_s3, glb_q);
    end
  end

  logic g_thermal_shutdown_event, g_otw, pwr_q, zc_q;
  assign g_thermal_shutdown_event = glb_q[0];
  assign g_otw = glb_q[1];
  assign pwr_q = glb_q[2];
  assign zc_q = glb_q[3];

  // init sequence: error pin held low until ready
  apfm_state_t state;
  logic [4:0] init_cnt;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= APFM_INIT;
      init_cnt <= 5'h00;
    end else begin
      case (state)
        APFM_INIT: begin
          init_cnt <= init_cnt + 5'h01;
          if (init_cnt == 5'(INIT_CYC - 1)) state <= APFM_RUN;
        end
        APFM_RUN: state <= APFM_RUN;
        default: state <= APFM_INIT;
      endcase
    end
  end
  assign ready = (state == APFM_RUN);

  // configuration passthrough to analog, dc offset threshold fixed at 0
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shutdown_current_threshold <= 2'h0;
      dynamic_current_limit <= 2'h0;
      dc_offset_threshold <= 2'h0;
      clip_level <= 2'h0;
      global_warn_threshold <= 2'h0;
    end else begin
      shutdown_current_threshold <= oc_level;
      dynamic_current_limit <= oc_level;
      dc_offset_threshold <= 2'h0;
      clip_level <= clip_threshold;
      global_warn_threshold <= global_warn_level;
    end
  end

  // per-channel limiter monitoring
  logic [23:0] win_cnt;
  logic [23:0] lim_cnt [4];
  logic [24:0] lcw_cnt [4];
  logic [17:0] run_cnt [4];
  logic [3:0] lcw_now, lcf_set;
  logic win_end;
  assign win_end = (win_cnt == 24'(WIN_CYC - 1));

  always_ff @(posedge clk) begin
    if (!reset_n) win_cnt <= 24'h000000;
    else win_cnt <= win_end ? 24'h000000 : win_cnt + 24'h000001;
  end

  for (genvar i = 0; i < 4; i++) begin : g_ch
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        lim_cnt[i] <= 24'h000000;
        lcw_now[i] <= 1'b0;
      end else if (win_end) begin
        lcw_now[i] <= ((lim_cnt[i] + {23'h0, lim_q[i]}) >= 24'(WIN_CYC / 2));
        lim_cnt[i] <= 24'h000000;
      end else begin
        lim_cnt[i] <= lim_cnt[i] + {23'h0, lim_q[i]};
      end
    end
    always_ff @(posedge clk) begin
      if (!reset_n) lcw_cnt[i] <= 25'h0000000;
      else if (!lcw_now[i]) lcw_cnt[i] <= 25'h0000000;
      else if (lcw_cnt[i] != 25'(LCF_CYC)) lcw_cnt[i] <= lcw_cnt[i] + 25'h0000001;
    end
    always_ff @(posedge clk) begin
      if (!reset_n) run_cnt[i] <= 18'h00000;
      else if (!lim_q[i]) run_cnt[i] <= 18'h00000;
      else if (run_cnt[i] != 18'(LIM4_CYC + 1)) run_cnt[i] <= run_cnt[i] + 18'h00001;
    end
    assign lcf_set[i] = (lcw_cnt[i] == 25'(LCF_CYC - 1))
      || (oc_level == 2'(APFM_OC_L4) && run_cnt[i] == 18'(LIM4_CYC));
  end

  // latched event flags, set wins over clear
  logic [3:0] ch_thermal_shutdown_event_any;
  assign ch_thermal_shutdown_event_any = cts_q | {4{g_thermal_shutdown_event}};
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overcurrent_shutdown_event <= 4'h0;
      dc_fault_event <= 4'h0;
      load_warning_event <= 4'h0;
      load_fault_event <= 4'h0;
      clip_warning_event <= 4'h0;
      thermal_shutdown_event <= 4'h0;
      thermal_warning_event <= 4'h0;
      global_thermal_warning_event <= 1'b0;
      power_fault_event <= 1'b0;
    end else begin
      overcurrent_shutdown_event <= (overcurrent_shutdown_event & ~clear_overcurrent_shutdown_event) | oc_q;
      dc_fault_event <= (dc_fault_event & ~clear_dc) | (dc_q & ~channel_hiz);
      load_warning_event <= (load_warning_event & ~clear_lcw) | (lcw_now & {4{win_end}});
      load_fault_event <= (load_fault_event & ~clear_lcf) | lcf_set;
      clip_warning_event <= (clip_warning_event & ~clear_clip) | (clp_q & {4{clip_enable}});
      thermal_shutdown_event <= (thermal_shutdown_event & ~clear_thermal_shutdown_event) | ch_thermal_shutdown_event_any;
      thermal_warning_event <= (thermal_warning_event & ~{4{clear_otw}}) | ctw_q;
      global_thermal_warning_event <= (global_thermal_warning_event & ~clear_otw) | g_otw;
      power_fault_event <= (power_fault_event & ~clear_power) | pwr_q;
    end
  end

  // protective shutdown per channel
  logic [3:0] latched_sd, thermal_sd;
  assign latched_sd = overcurrent_shutdown_event | dc_fault_event | load_fault_event;
  assign thermal_sd = auto_recover ? ch_thermal_shutdown_event_any : thermal_shutdown_event;
  always_ff @(posedge clk) begin
    if (!reset_n) channel_hiz <= 4'hf;
    else channel_hiz <= latched_sd | thermal_sd | {4{pwr_q}} | oc_q;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) dynamic_current_limit_en <= 4'h0;
    else dynamic_current_limit_en <= ~channel_hiz;
  end

  // thermal gain foldback
  logic any_warn;
  logic [15:0] rate_cnt;
  logic [7:0] zc_cnt;
  logic step_due, zc_ok, want_down, want_up;
  assign any_warn = g_otw | (|ctw_q);
  assign want_down = foldback_enable && any_warn && atten_steps != `APFM_GAIN_MAX_STEPS;
  assign want_up = !(foldback_enable && any_warn) && atten_steps != 5'h00;
  assign step_due = rate_cnt >= (want_down ? attack_cyc : release_cyc);
  assign zc_ok = !zc_enable || (zc_cnt >= zc_wait_cyc);

  always_ff @(posedge clk) begin
    if (!reset_n) rate_cnt <= 16'h0000;
    else if (!(want_down || want_up) || (step_due && zc_ok)) rate_cnt <= 16'h0000;
    else if (!step_due) rate_cnt <= rate_cnt + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) zc_cnt <= 8'h00;
    else if (!zc_q) zc_cnt <= 8'h00;
    else if (zc_cnt != 8'hff) zc_cnt <= zc_cnt + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) atten_steps <= 5'h00;
    else if (step_due && zc_ok && want_down) atten_steps <= atten_steps + 5'h01;
    else if (step_due && zc_ok && want_up) atten_steps <= atten_steps - 5'h01;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) thermal_gain_reduction <= 1'b0;
    else thermal_gain_reduction <= (atten_steps != 5'h00);
  end

  // fault, warning and clip signals
  logic [7:0] fsrc, wsrc;
  always_comb begin
    fsrc = 8'h00;
    fsrc[`APFM_F_OVERCURRENT_SHUTDOWN_EVENT] = |overcurrent_shutdown_event;
    fsrc[`APFM_F_DC] = |dc_fault_event;
    fsrc[`APFM_F_LCF] = |load_fault_event;
    fsrc[`APFM_F_THERMAL_SHUTDOWN_EVENT] = |thermal_shutdown_event;
    fsrc[`APFM_F_PWR] = power_fault_event;
    fsrc[`APFM_F_PSD] = |channel_hiz;
    fsrc[`APFM_F_WARN] = warning_signal;
    wsrc = 8'h00;
    wsrc[`APFM_W_OTW] = global_thermal_warning_event | (|thermal_warning_event);
    wsrc[`APFM_W_THERMAL_GAIN_REDUCTION] = thermal_gain_reduction;
    wsrc[`APFM_W_LCW] = |load_warning_event;
    wsrc[`APFM_W_PWR] = power_fault_event;
    wsrc[`APFM_W_THERMAL_SHUTDOWN_EVENT] = |thermal_shutdown_event;
    wsrc[`APFM_W_CLIP] = |clip_warning_event;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_signal <= 1'b0;
      warning_signal <= 1'b0;
      clip_group <= 2'h0;
    end else begin
      fault_signal <= |(fsrc & (fault_cfg1 | fault_cfg2));
      warning_signal <= |(wsrc & warn_cfg);
      clip_group <= {grp_sel(clip_map_grp2, clip_warning_event), grp_sel(clip_map_grp1, clip_warning_event)};
    end
  end

  // pin muxes only read signals, protection untouched
  always_comb begin
    fault_pin_o = 1'b0;
    fault_pin_oe = 1'b1;
    if (ready) begin
      case (fault_pin_sel)
        `APFM_PIN_FAULT: fault_pin_oe = fault_signal;
        `APFM_PIN_WARN: fault_pin_oe = warning_signal;
        `APFM_PIN_CLIP1: fault_pin_o = clip_group[0];
        `APFM_PIN_CLIP2: fault_pin_o = clip_group[1];
        default: fault_pin_oe = fault_signal;
      endcase
    end
  end

  // gpio pins, result is {oe, o}
  function automatic logic [1:0] gp_mux(input logic [3:0] s, input logic w, input logic f, input logic [1:0] g);
    case (s)
      `APFM_GP_WARN: gp_mux = {w, 1'b0};
      `APFM_GP_FAULT: gp_mux = {f, 1'b0};
      `APFM_GP_CLIP1: gp_mux = {1'b1, g[0]};
      `APFM_GP_CLIP2: gp_mux = {1'b1, g[1]};
      default: gp_mux = 2'h0;
    endcase
  endfunction
  assign {general_pin_a_oe, general_pin_a_o} = gp_mux(gpio_a_sel, warning_signal, fault_signal, clip_group);
  assign {general_pin_b_oe, general_pin_b_o} = gp_mux(gpio_b_sel, warning_signal, fault_signal, clip_group);

endmodule

// File: dv/apfm_props.sv
`timescale 1ns/1ps
module apfm_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic global_ot_shutdown,
  input wire logic supply_fault,
  input wire logic [1:0] oc_level,
  input wire logic [7:0] fault_cfg1,
  input wire logic [3:0] fault_pin_sel,
  input wire logic [3:0] channel_hiz,
  input wire logic [3:0] overcurrent_shutdown_event,
  input wire logic [3:0] dc_fault_event,
  input wire logic [3:0] load_fault_event,
  input wire logic [3:0] thermal_shutdown_event,
  input wire logic power_fault_event,
  input wire logic [1:0] shutdown_current_threshold,
  input wire logic [4:0] atten_steps,
  input wire logic thermal_gain_reduction,
  input wire logic fault_signal,
  input wire logic warning_signal,
  input wire logic [1:0] clip_group,
  input wire logic ready,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  init_pin_low_a: assert property (!ready |-> fault_pin_oe && !fault_pin_o)
    else $error("fault pin released before ready");
  oc_hiz_a: assert property ($rose(overcurrent_shutdown_event[0]) |-> ##[0:1] channel_hiz[0])
    else $error("overcurrent did not shut channel down");
  dc_hiz_a: assert property ($rose(dc_fault_event[1]) |-> ##[0:1] channel_hiz[1])
    else $error("dc fault did not shut channel down");
  lcf_hiz_a: assert property ($rose(load_fault_event[3]) |-> ##[0:1] channel_hiz[3])
    else $error("load fault did not shut channel down");
  ot_hiz_a: assert property ($rose(thermal_shutdown_event[2]) && !global_ot_shutdown |-> ##[0:1] channel_hiz[2])
    else $error("channel thermal shutdown missing");
  glob_hiz_a: assert property ($rose(global_ot_shutdown) |-> ##[4:7] channel_hiz == 4'hf)
    else $error("global thermal shutdown missing");
  fault_sig_a: assert property ($rose(overcurrent_shutdown_event[0]) && fault_cfg1[0] |-> ##[1:2] fault_signal)
    else $error("fault signal not raised");
  pin_fault_a: assert property (ready && fault_pin_sel == 4'h0 |-> fault_pin_oe == fault_signal)
    else $error("fault pin does not follow fault signal");
  pin_warn_a: assert property (ready && fault_pin_sel == 4'h1 |-> fault_pin_oe == warning_signal)
    else $error("fault pin does not follow warning signal");
  pin_clip_a: assert property (ready && fault_pin_sel == 4'h2 |-> (!fault_pin_oe || fault_pin_o) == clip_group[0])
    else $error("fault pin does not follow clip group");
  oc_thr_a: assert property (shutdown_current_threshold == $past(oc_level))
    else $error("threshold does not follow level");
  atten_step_a: assert property (atten_steps <= 5'h18 && (atten_steps == $past(atten_steps)
    || atten_steps == $past(atten_steps) + 5'h1 || atten_steps + 5'h1 == $past(atten_steps)))
    else $error("attenuation step out of range");
  tgr_flag_a: assert property (thermal_gain_reduction == ($past(atten_steps) != 5'h0))
    else $error("foldback warning wrong");
  pwr_event_a: assert property ($rose(supply_fault) |-> ##[3:6] power_fault_event)
    else $error("power fault event missing");
  cover property (load_fault_event[3]);
  cover property (atten_steps == 5'h18);
  cover property (fault_pin_sel == 4'h2 && clip_group[0]);
endmodule
bind apfm_monitor apfm_props apfm_props_inst (.*);

// File: dv/apfm_host.sv
`timescale 1ns/1ps
module apfm_host (
  input wire logic clk,
  input wire logic ready,
  input wire logic [3:0] want_sel,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe,
  output logic [3:0] fault_pin_sel,
  output wire fault_line
);
  // pulled-up open-drain line
  assign fault_line = !(fault_pin_oe && !fault_pin_o);
  initial fault_pin_sel = 4'h0;
  // reconfigure only once the device talks
  always @(posedge clk) if (ready) fault_pin_sel <= #1 want_sel;
endmodule

// File: dv/apfm_monitor_bench.sv
`timescale 1ns/1ps
module apfm_monitor_bench;
  import apfm_pkg::*;
  logic clk = 0, reset_n = 0, global_ot_shutdown = 0, global_ot_warning = 0, supply_fault = 0, zero_cross = 1;
  logic [3:0] oc_detect = '0, dc_detect = '0, limit_active = '0, clip_detect = '0, ch_ot_shutdown = '0;
  logic [3:0] ch_ot_warning = '0, gpio_a_sel = 4'h1, gpio_b_sel = 4'h2, want_sel = '0, fault_pin_sel;
  logic [1:0] oc_level = '0, global_warn_level, clip_threshold, clip_map_grp1 = '0, clip_map_grp2 = 2'h1;
  logic clip_enable = 1, auto_recover = 1, foldback_enable = 1, zc_enable = 1, clear_power = 0, clear_otw = 0;
  logic [7:0] zc_wait_cyc = 8'h0a, fault_cfg1 = 8'h0f, fault_cfg2 = '0, warn_cfg = 8'h01;
  logic [15:0] attack_cyc = 16'h2, release_cyc = 16'h2;
  logic [3:0] clear_overcurrent_shutdown_event = '0, clear_dc = '0, clear_lcf = '0, clear_lcw = '0, clear_clip = '0, clear_thermal_shutdown_event = '0;
  logic [3:0] dynamic_current_limit_en, channel_hiz, overcurrent_shutdown_event, dc_fault_event, load_warning_event;
  logic [3:0] load_fault_event, clip_warning_event, thermal_shutdown_event, thermal_warning_event, hz_prev = 4'hf;
  logic [1:0] shutdown_current_threshold, dynamic_current_limit, dc_offset_threshold, clip_level;
  logic [1:0] global_warn_threshold, clip_group, grp_exp;
  logic [4:0] atten_steps;
  logic global_thermal_warning_event, power_fault_event, thermal_gain_reduction, fault_signal, warning_signal;
  logic ready, fault_pin_o, fault_pin_oe, general_pin_a_o, general_pin_a_oe, general_pin_b_o, general_pin_b_oe;
  wire fault_line;
  logic [3:0] hz_q[$];
  bit watch = 0;
  int n_errors = 0, checks = 0, w, n;
  apfm_monitor #(.WIN_CYC(100), .LCF_CYC(400), .LIM4_CYC(20), .INIT_CYC(16)) apfm_monitor_inst (.*);
  apfm_host apfm_host_inst (.*);
  always #25 clk = ~clk;
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic hold(logic [3:0] v);
    for (int i = 0; i < 800 && channel_hiz !== v; i++) step(1);
    if (channel_hiz !== v) begin
      n_errors++;
      summarize();
    end
  endtask
  // scoreboard: each shutdown change must match the oldest note
  always @(negedge clk) if (watch && channel_hiz !== hz_prev) begin
    hz_prev = channel_hiz;
    chk("channel_hiz", channel_hiz, hz_q.size() ? hz_q.pop_front() : 4'hx);
  end
  task automatic trip(ref logic [3:0] det, ref logic [3:0] clr, input bit dc, input logic [3:0] m);
    hz_q.push_back(m);
    det = m;
    step(w);
    det = '0;
    hold(m);
    step(8);
    chk("event", dc ? dc_fault_event : overcurrent_shutdown_event, m);
    chk("fault_line", fault_line, 1'b0);
    chk("gpio_fault", general_pin_b_oe, 1'b1);
    hz_q.push_back(4'h0);
    clr = m;
    step(1);
    clr = '0;
    hold(4'h0);
    step(2);
    chk("fault_line", fault_line, 1'b1);
  endtask
  initial begin
    void'($urandom(32'hd502f791));
    clip_threshold = 2'($urandom_range(3, 0));
    global_warn_level = 2'($urandom_range(3, 0));
    w = $urandom_range(9, 4);
    clip_map_grp1 = 2'($urandom_range(3, 0));
    clip_map_grp2 = 2'($urandom_range(3, 0));
    grp_exp = {clip_map_grp2 == 2'h0 || clip_map_grp2 == 2'h2, clip_map_grp1 == 2'h0 || clip_map_grp1 == 2'h2};
    zc_wait_cyc = 8'($urandom_range(20, 1));
    attack_cyc = 16'($urandom_range(4, 1));
    release_cyc = 16'($urandom_range(4, 1));
    fault_cfg2 = 8'($urandom) & 8'h2f;
    repeat (6) @(posedge clk);
    #1 reset_n = 1;
    for (n = 0; n < 40 && ready !== 1'b1; n++) begin
      chk("init_pin", fault_line, 1'b0);
      step(1);
    end
    chk("init_len", 8'(n), 8'd16);
    chk("warn_thr", global_warn_threshold, global_warn_level);
    chk("clip_lvl", clip_level, clip_threshold);
    hz_q.push_back(4'h0);
    watch = 1;
    trip(oc_detect, clear_overcurrent_shutdown_event, 0, 4'h1);
    trip(dc_detect, clear_dc, 1, 4'h2);
    hz_q.push_back(4'h4);
    ch_ot_shutdown[2] = 1;
    hold(4'h4);
    chk("thermal_shutdown_event_ev", thermal_shutdown_event, 4'h4);
    hz_q.push_back(4'h0);
    ch_ot_shutdown[2] = 0;
    hold(4'h0);
    hz_q.push_back(4'hf);
    global_ot_shutdown = 1;
    hold(4'hf);
    hz_q.push_back(4'h0);
    global_ot_shutdown = 0;
    hold(4'h0);
    clear_thermal_shutdown_event = 4'hf;
    step(1);
    clear_thermal_shutdown_event = '0;
    limit_active[1] = 1;
    step(300);
    chk("lcw_ev", load_warning_event, 4'h2);
    hz_q.push_back(4'h2);
    hold(4'h2);
    limit_active[1] = 0;
    oc_level = 2'h3;
    step(120);
    hz_q.push_back(4'h0);
    {clear_lcf, clear_lcw} = 8'h22;
    step(1);
    {clear_lcf, clear_lcw} = '0;
    hold(4'h0);
    hz_q.push_back(4'h8);
    limit_active[3] = 1;
    for (n = 0; n < 40 && channel_hiz !== 4'h8; n++) step(1);
    chk("lim4_time", n >= 20 && n < 40, 1'b1);
    limit_active[3] = 0;
    oc_level = '0;
    step(120);
    hz_q.push_back(4'h0);
    {clear_lcf, clear_lcw} = 8'h88;
    step(1);
    {clear_lcf, clear_lcw} = '0;
    hold(4'h0);
    clip_detect[0] = 1;
    step(8);
    chk("clip_ev", clip_warning_event, 4'h1);
    chk("clip_grp", clip_group, grp_exp);
    gpio_a_sel = 4'h0;
    for (int s = 2; s < 4; s++) begin
      want_sel = s[3:0];
      gpio_b_sel = 4'(s + 1);
      step(3);
      chk("clip_pin", fault_line, grp_exp[s - 2]);
      chk("gpio_clip", {general_pin_b_oe, general_pin_b_o}, {1'b1, grp_exp[s - 2]});
      chk("gpio_hiz", general_pin_a_oe, 1'b0);
    end
    gpio_a_sel = 4'h1;
    chk("clip_keep", clip_warning_event, 4'h1);
    clip_detect[0] = 0;
    want_sel = 4'h1;
    step(4);
    clear_clip = 4'h1;
    step(1);
    clear_clip = '0;
    clip_enable = 0;
    clip_detect[0] = 1;
    step(8);
    chk("clip_off", clip_warning_event, 4'h0);
    clip_detect[0] = 0;
    zero_cross = 0;
    ch_ot_warning[0] = 1;
    global_ot_warning = 1;
    step(100);
    chk("zc_gate", atten_steps, 5'h0);
    zero_cross = 1;
    for (n = 0; n < 3000 && atten_steps !== 5'h18; n++) step(1);
    chk("atten_max", atten_steps, 5'h18);
    chk("tgr", thermal_gain_reduction, 1'b1);
    chk("warn_pin", fault_line, 1'b0);
    chk("gpio_warn", general_pin_a_oe, 1'b1);
    chk("g_otw_ev", global_thermal_warning_event, 1'b1);
    ch_ot_warning[0] = 0;
    global_ot_warning = 0;
    step(8);
    clear_otw = 1;
    step(1);
    clear_otw = 0;
    for (n = 0; n < 3000 && atten_steps !== 5'h0; n++) step(1);
    chk("atten_rel", atten_steps, 5'h0);
    step(2);
    chk("tgr_off", thermal_gain_reduction, 1'b0);
    chk("warn_off", fault_line, 1'b1);
    chk("queue_left", 8'(hz_q.size()), 8'h0);
    watch = 0;
    supply_fault = 1;
    step(8);
    chk("pwr_ev", power_fault_event, 1'b1);
    supply_fault = 0;
    step(8);
    clear_power = 1;
    step(1);
    clear_power = 0;
    step(1);
    chk("pwr_clr", power_fault_event, 1'b0);
    summarize();
  end
endmodule
